// file: src/irq_unit.sv
`include "irq_unit_defines.svh"
module irq_unit
  import irq_unit_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] i_pstrb_unused,
  input wire logic [17:0] i_src_event,
  input wire logic [17:0] i_periph_flag,
  input wire logic i_instr_done,
  input wire logic i_return_from_service,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic o_long_subroutine_call,
  output logic [15:0] o_call_vector,
  output logic [1:0] o_in_service
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  src_vec_t enable_q;
  src_vec_t prio_q;
  src_vec_t pend_q;
  logic global_irq_allow_q;
  logic ins_lo_q;
  logic ins_hi_q;
  logic hold_q;
  logic cand_valid_q;
  logic cand_hi_q;
  src_idx_t cand_idx_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic call_q;
  logic [15:0] vector_q;

  logic access;
  logic wr_en;
  logic [7:0] ofs;
  logic mapped;
  src_vec_t req;
  src_vec_t req_hi;
  src_vec_t req_lo;
  logic grant;
  src_vec_t grant_mask;
  src_vec_t sw_set;
  src_vec_t sw_clr;

  ////////////////////////////////////////////////////////////////////////
  // apb decode; one wait state keeps every answer registered
  assign access = i_psel && i_penable && !pready_q;
  assign wr_en = access && i_pwrite;
  assign ofs = i_paddr[7:0];
  assign mapped = (i_paddr[31:8] == 24'h000000) &&
                  (ofs == `OFS_ENABLE || ofs == `OFS_PRIORITY ||
                   ofs == `OFS_PEND_SET || ofs == `OFS_PEND_CLR ||
                   ofs == `OFS_STATUS);

  // bus answer and read mux
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access;
      pslverr_q <= access && !mapped;
      prdata_q <= 32'h00000000;
      if (access && !i_pwrite) begin
        case (ofs)
          `OFS_ENABLE: prdata_q <= {global_irq_allow_q, 13'h0000, enable_q};
          `OFS_PRIORITY: prdata_q <= {14'h0000, prio_q};
          `OFS_PEND_SET: prdata_q <= {14'h0000, pend_q | i_periph_flag};
          `OFS_STATUS: prdata_q <= {28'h0000000, hold_q, cand_valid_q,
                                    ins_hi_q, ins_lo_q};
          default: prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable and priority configuration
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      enable_q <= `RST_ENABLE;
      global_irq_allow_q <= 1'b0;
      prio_q <= `RST_PRIORITY;
    end else if (wr_en) begin
      if (ofs == `OFS_ENABLE) begin
        enable_q <= i_pwdata[17:0];
        global_irq_allow_q <= i_pwdata[`GLOBAL_BIT];
      end
      if (ofs == `OFS_PRIORITY) begin
        prio_q <= i_pwdata[17:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending flags; a set always wins over a clear in the same cycle
  assign sw_set = (wr_en && ofs == `OFS_PEND_SET) ? i_pwdata[17:0] : 18'h00000;
  assign sw_clr = (wr_en && ofs == `OFS_PEND_CLR) ? i_pwdata[17:0] : 18'h00000;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_q <= 18'h00000;
    end else begin
      // auto-clear on vectoring for selected sources
      pend_q <= (pend_q & ~sw_clr & ~(grant_mask & `AUTO_CLR_MASK))
                | i_src_event | sw_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request forming
  // flags of one source ORed
  assign req = (pend_q | i_periph_flag) & enable_q
               & {`NUM_SRC{global_irq_allow_q}};
  assign req_hi = req & prio_q;
  assign req_lo = req & ~prio_q;

  // lowest set index of a source vector
  function automatic src_idx_t first_set(input src_vec_t v);
    src_idx_t idx;
    idx = 5'h00;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cand_valid_q <= 1'b0;
      cand_hi_q <= 1'b0;
      cand_idx_q <= 5'h00;
    end else begin
      if (|req_hi) begin
        cand_valid_q <= !ins_hi_q;
        cand_hi_q <= 1'b1;
        cand_idx_q <= first_set(req_hi);
      end else begin
        cand_valid_q <= (|req_lo) && !ins_hi_q && !ins_lo_q;
        cand_hi_q <= 1'b0;
        cand_idx_q <= first_set(req_lo);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vectoring; the cpu spends four more cycles on the call itself
  // call at instruction boundary
  assign grant = cand_valid_q && i_instr_done && !hold_q && !call_q
                 && !(cand_hi_q ? ins_hi_q : (ins_hi_q || ins_lo_q));
  always_comb begin
    grant_mask = 18'h00000;
    if (grant) begin
      grant_mask[cand_idx_q] = 1'b1;
    end
  end

  // call pulse and vector
  // async reset overrides any call
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      call_q <= 1'b0;
      vector_q <= 16'h0000;
    end else begin
      call_q <= grant;
      if (grant) begin
        vector_q <= `VEC_BASE + `VEC_STEP * {11'h000, cand_idx_q};
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_q <= 1'b0;
    end else if (i_return_from_service) begin
      hold_q <= 1'b1;
    end else if (i_instr_done) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ins_lo_q <= 1'b0;
      ins_hi_q <= 1'b0;
    end else if (grant) begin
      if (cand_hi_q) begin
        ins_hi_q <= 1'b1;
      end else begin
        ins_lo_q <= 1'b1;
      end
    end else if (i_return_from_service) begin
      // return ends the innermost level only
      if (ins_hi_q) begin
        ins_hi_q <= 1'b0;
      end else begin
        ins_lo_q <= 1'b0;
      end
    end
  end

  assign o_pready = pready_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;
  assign o_long_subroutine_call = call_q;
  assign o_call_vector = vector_q;
  assign o_in_service = {ins_hi_q, ins_lo_q};

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_prio_reset;
    @(posedge i_clock) !$past(i_reset_n) |-> prio_q == 18'h00000;
  endproperty
  a_prio_reset: assert property (p_prio_reset) else $error("priority not low after reset");

  property p_global;
    @(posedge i_clock) disable iff (!i_reset_n)
      call_q |-> $past(global_irq_allow_q, 2);
  endproperty
  a_global: assert property (p_global) else $error("call with global allow off");

  property p_vector;
    @(posedge i_clock) disable iff (!i_reset_n)
      call_q |-> vector_q == 16'h0003 + 16'h0008 * {11'h000, $past(cand_idx_q)};
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");

  property p_hi_first;
    @(posedge i_clock) disable iff (!i_reset_n)
      (|req_hi && !ins_hi_q) |=> cand_hi_q && cand_valid_q;
  endproperty
  a_hi_first: assert property (p_hi_first) else $error("high request lost arbitration");

  property p_order;
    @(posedge i_clock) disable iff (!i_reset_n)
      (|req_hi) |=> cand_idx_q == first_set($past(req_hi));
  endproperty
  a_order: assert property (p_order) else $error("wrong fixed order");

  property p_no_preempt_hi;
    @(posedge i_clock) disable iff (!i_reset_n)
      call_q |-> !$past(ins_hi_q);
  endproperty
  a_no_preempt_hi: assert property (p_no_preempt_hi) else $error("high service preempted");

  property p_hold;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_return_from_service ##1 !i_instr_done |-> !call_q ##1 !call_q;
  endproperty
  a_hold: assert property (p_hold) else $error("call before one instruction");

  property p_marker;
    @(posedge i_clock) disable iff (!i_reset_n)
      grant && cand_hi_q |=> ins_hi_q && call_q;
  endproperty
  a_marker: assert property (p_marker) else $error("high marker not set");

  property p_autoclr;
    @(posedge i_clock) disable iff (!i_reset_n)
      grant && cand_idx_q == 5'h00 && !i_src_event[0] && !sw_set[0] |=> !pend_q[0];
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("flag not auto-cleared");

  // idle unit answers a fresh request at the first free boundary
  property p_best_case;
    @(posedge i_clock) disable iff (!i_reset_n)
      (|req) && !ins_hi_q && !ins_lo_q && !grant ##1 (i_instr_done && !hold_q && !call_q) |=> call_q;
  endproperty
  a_best_case: assert property (p_best_case) else $error("fast response missed");

  property p_global_mask;
    @(posedge i_clock) disable iff (!i_reset_n)
      !global_irq_allow_q |=> !cand_valid_q;
  endproperty
  a_global_mask: assert property (p_global_mask) else $error("candidate with global allow off");

  property p_low_blocked;
    @(posedge i_clock) disable iff (!i_reset_n)
      ins_lo_q && !(|req_hi) |=> !cand_valid_q;
  endproperty
  a_low_blocked: assert property (p_low_blocked) else $error("low request not held off");

  property p_flag_set;
    @(posedge i_clock) disable iff (!i_reset_n)
      (|i_src_event) |=> (pend_q & $past(i_src_event)) == $past(i_src_event);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

  property p_sw_set;
    @(posedge i_clock) disable iff (!i_reset_n)
      (|sw_set) |=> (pend_q & $past(sw_set)) == $past(sw_set);
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set lost");

  property p_reset_quiet;
    @(posedge i_clock) !$past(i_reset_n) |-> !call_q && !ins_hi_q && !ins_lo_q;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("service state after reset");

endmodule

// file: src/irq_unit_defines.svh
`ifndef IRQ_UNIT_DEFINES_SVH
`define IRQ_UNIT_DEFINES_SVH
`define NUM_SRC 18
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define OFS_ENABLE 8'h00
`define OFS_PRIORITY 8'h04
`define OFS_PEND_SET 8'h08
`define OFS_PEND_CLR 8'h0C
`define OFS_STATUS 8'h10
`define GLOBAL_BIT 31
`define RST_ENABLE 18'h00000
`define RST_PRIORITY 18'h00000
`define AUTO_CLR_MASK 18'h1000F
`define DETECT_CYCLES 1
`define CALL_CYCLES 4
`endif

// file: src/irq_unit_pkg.sv
package irq_unit_pkg;
  typedef logic [17:0] src_vec_t;
  typedef logic [4:0] src_idx_t;
  typedef enum logic {
    LEVEL_LOW,
    LEVEL_HIGH
  } level_e;
endpackage

// file: sim/cpu_model.sv
// stand-in for the core sequencer: retires an instruction every idle cycle
module cpu_model (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_call,
  input wire logic i_ret_req,
  output logic o_instr_done,
  output logic o_return
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] busy_q;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_q <= 3'h0;
    end else if (i_call) begin
      busy_q <= 3'h4;
    end else if (busy_q != 3'h0) begin
      busy_q <= busy_q - 3'h1;
    end
  end
  // return retires alone, then one plain instruction follows
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_instr_done <= 1'b0;
      o_return <= 1'b0;
    end else begin
      o_instr_done <= (busy_q == 3'h0) && !i_call && !i_ret_req;
      o_return <= i_ret_req;
    end
  end
endmodule

// file: sim/test_two_level_vectored_interrupt_unit.sv
`include "irq_unit_defines.svh"
module test_two_level_vectored_interrupt_unit;
  import irq_unit_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ret_req = 0, done, ret;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [17:0] ev = 0, pflag = 0;
  logic pready, pslverr, call;
  logic [15:0] vec;
  logic [1:0] insv;
  int failures = 0, n_compared = 0, cyc = 0;
  always #4 clk = ~clk;
  irq_unit i_dut (.i_clock(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb_unused(32'h0), .i_src_event(ev),
    .i_periph_flag(pflag), .i_instr_done(done), .i_return_from_service(ret), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .o_long_subroutine_call(call), .o_call_vector(vec),
    .o_in_service(insv));
  cpu_model i_cpu (.i_clock(clk), .i_reset_n(rst_n), .i_call(call), .i_ret_req(ret_req),
    .o_instr_done(done), .o_return(ret));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // setup, then access held until pready seen high at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", {31'h0, a > 32'h10}, {31'h0, pslverr});
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // waits a bounded time for the call, checks vector, clears, returns
  task automatic svc(input int s, input logic [31:0] clr, input logic [1:0] lvl);
    int n;
    n = 0;
    while (call !== 1'b1 && n < 12) begin
      @(posedge clk);
      n++;
    end
    chk("vector", 32'h3 + 32'h8 * s, {16'h0, vec});
    @(posedge clk);
    chk("in service", {30'h0, lvl}, {30'h0, insv});
    apb(1, `OFS_PEND_CLR, clr);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk("in service end", 32'h0, {30'h0, insv});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(0, `OFS_PRIORITY, 0);
    chk("priority reset", 32'h0, rd);
    apb(0, `OFS_ENABLE, 0);
    chk("enable reset", 32'h0, rd);
    apb(0, 32'h14, 0);
    chk("unmapped read", 32'h0, rd);
    $display("reset test done");
  endtask
  task automatic t_mask();
    ev[7] <= 1'b1;
    @(posedge clk);
    ev[7] <= 1'b0;
    repeat (8) @(posedge clk);
    chk("masked call", 32'h0, {31'h0, call});
    apb(0, `OFS_PEND_SET, 0);
    chk("pending", 32'h80, rd);
    apb(1, `OFS_PEND_CLR, 32'h80);
    $display("mask test done");
  endtask
  task automatic t_vectors();
    apb(1, `OFS_ENABLE, 32'h8003FFFF);
    for (int s = 0; s < 18; s++) begin
      apb(1, `OFS_PEND_SET, 32'h1 << s);
      svc(s, 32'h1 << s, 2'h1);
    end
    $display("vector test done");
  endtask
  task automatic t_prio();
    apb(1, `OFS_PRIORITY, 32'h200);
    apb(1, `OFS_PEND_SET, 32'h220);
    svc(9, 32'h220, 2'h2);
    apb(1, `OFS_PRIORITY, 32'h0);
    apb(1, `OFS_PEND_SET, 32'h220);
    svc(5, 32'h220, 2'h1);
    pflag[15] <= 1'b1;
    svc(15, 32'h0, 2'h1);
    pflag[15] <= 1'b0;
    svc(15, 32'h0, 2'h1);
    apb(1, `OFS_PEND_SET, 32'h10000);
    svc(16, 32'h0, 2'h1);
    apb(0, `OFS_PEND_SET, 0);
    chk("auto clear", 32'h0, rd);
    $display("priority test done");
  endtask
  ////////////////////////////////////////////////////////////////
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_mask();
    t_vectors();
    t_prio();
    give_verdict();
  end
endmodule
